/* File: verilog/nand_seq_pkg.sv */
/*
  Constants for the flash command sequencer: command codes, status byte
  layout, address cycle layout and operation times.
  Assumes a 20 MHz system clock.
*/
package nand_seq_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;

  // Command codes
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_READ_GO   = 8'h30;
  localparam logic [7:0] CMD_LOAD      = 8'h80;
  localparam logic [7:0] CMD_COL_CHG   = 8'h85;
  localparam logic [7:0] CMD_PROG      = 8'h10;
  localparam logic [7:0] CMD_PROG_CACH = 8'h15;
  localparam logic [7:0] CMD_ERASE     = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_RESET     = 8'hFF;

  // Status byte bit positions
  localparam int unsigned ST_FAIL_BIT  = 0;
  localparam int unsigned ST_PBRDY_BIT = 5;
  localparam int unsigned ST_CRDY_BIT  = 6;
  localparam int unsigned ST_WP_BIT    = 7;

  // Address cycles: two column, two row (erase setup: two row only); a fifth is dropped
  localparam logic [2:0] ADDR_COL_LO = 3'h0;
  localparam logic [2:0] ADDR_COL_HI = 3'h1;
  localparam logic [2:0] ADDR_ROW_LO = 3'h2;
  localparam logic [2:0] ADDR_ROW_HI = 3'h3;
  localparam logic [2:0] ADDR_LAST   = 3'h4;

  // Operation times in ns
  localparam int unsigned T_READ_NS  = 25000;
  localparam int unsigned T_PROG_NS  = 300000;
  localparam int unsigned T_ERASE_NS = 2500000;
  localparam int unsigned T_RST_NS   = 5000;
  localparam int unsigned T_POR_NS   = 1000000;

  localparam logic [15:0] READ_CYC = 16'(T_READ_NS / CLK_PERIOD_NS);
  localparam logic [15:0] RST_CYC  = 16'(T_RST_NS / CLK_PERIOD_NS);

  // Sync vector layout
  localparam int unsigned PIN_W = 14;

endpackage : nand_seq_pkg

/* File: verilog/pin_sync.sv */
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes inputs are levels from outside the clk domain.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 14
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] init,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (srst) begin
          meta[i] <= init[i];
          q[i]    <= init[i];
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync

/* File: verilog/nand_seq.sv */
/*
  Command sequencer of a parallel NAND flash: decodes strobed command,
  address and data cycles, runs timed read, program and erase phases,
  answers status reads and drives the open-drain ready/busy pin.
  Assumes host strobes are slow against the 20 MHz clk and that the
  cell array answers on rd_data and array_fail in the clk domain.
*/
`timescale 1ns/1ps
module nand_seq #(
  parameter logic [15:0] PROG_CYC  =
    16'(nand_seq_pkg::T_PROG_NS / nand_seq_pkg::CLK_PERIOD_NS),
  parameter logic [15:0] ERASE_CYC =
    16'(nand_seq_pkg::T_ERASE_NS / nand_seq_pkg::CLK_PERIOD_NS),
  parameter logic [15:0] POR_CYC   =
    16'(nand_seq_pkg::T_POR_NS / nand_seq_pkg::CLK_PERIOD_NS)
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic        wp_n,
  input  wire logic [7:0]  io_in,
  output logic      [7:0]  io_out,
  output logic             io_oe_n,
  output logic             ready_busy_n,
  output logic             ready_busy_oe_n,
  input  wire logic [7:0]  rd_data,
  input  wire logic        array_fail,
  output logic      [11:0] col_addr,
  output logic      [15:0] row_addr,
  output logic             wr_strobe,
  output logic      [7:0]  wr_data,
  output logic             read_go,
  output logic             prog_go,
  output logic             erase_go,
  output logic             op_abort
);
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_RSET  = 3'b001,
    M_READ  = 3'b010,
    M_LOAD  = 3'b011,
    M_ESET  = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_READ  = 2'b01,
    OP_PROG  = 2'b10,
    OP_ERASE = 2'b11
  } op_t;

  typedef struct packed {
    mode_t       mode;
    op_t         op;
    logic        busy;
    logic        status_mode;
    logic        fail;
    logic [15:0] tmr;
    logic [2:0]  addr_cnt;
    logic [11:0] col;
    logic [15:0] row;
    logic        we_q;
    logic        re_q;
    logic [7:0]  io_out;
    logic        io_oe_n;
    logic        rb_oe_n;
    logic        wr_strobe;
    logic [7:0]  wr_data;
    logic        read_go;
    logic        prog_go;
    logic        erase_go;
    logic        op_abort;
  } state_t;

  state_t st;
  state_t next_st;

  logic [13:0] pins;
  logic        ce_s, cle_s, ale_s, we_s, re_s, wp_s;
  logic [7:0]  io_s;
  logic        we_rise, re_fall, cmd_ev, addr_ev, data_ev;
  logic [7:0]  status;

  pin_sync #(.W(nand_seq_pkg::PIN_W)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({ce_n, cle, ale, we_n, re_n, wp_n, io_in}),
    .init ({6'h27, 8'h00}),
    .q    (pins)
  );

  assign {ce_s, cle_s, ale_s, we_s, re_s, wp_s, io_s} = pins;
  assign we_rise = !ce_s && we_s && !st.we_q;
  assign re_fall = !ce_s && !re_s && st.re_q;
  assign cmd_ev  = we_rise && cle_s && !ale_s;
  assign addr_ev = we_rise && ale_s && !cle_s;
  assign data_ev = we_rise && !ale_s && !cle_s;
  assign status  = {wp_s, !st.busy, !st.busy, 4'h0, st.fail};

  always_comb begin
    next_st           = st;
    next_st.we_q      = we_s;
    next_st.re_q      = re_s;
    next_st.wr_strobe = 1'b0;
    next_st.read_go   = 1'b0;
    next_st.prog_go   = 1'b0;
    next_st.erase_go  = 1'b0;
    next_st.op_abort  = 1'b0;
    next_st.io_oe_n   = !(!ce_s && !re_s);

    // Timed phase end
    if (st.busy) begin
      if (st.tmr == 16'h0000) begin
        next_st.busy = 1'b0;
        next_st.op   = OP_NONE;
        if (st.op == OP_READ) begin
          next_st.mode = M_READ;
        end
        if (st.op == OP_PROG || st.op == OP_ERASE) begin
          next_st.fail = array_fail;
        end
      end else begin
        next_st.tmr = st.tmr - 16'h0001;
      end
      if (!wp_s && (st.op == OP_PROG || st.op == OP_ERASE)) begin
        next_st.busy     = 1'b0;
        next_st.op       = OP_NONE;
        next_st.fail     = 1'b1;
        next_st.op_abort = 1'b1;
      end
    end

    if (cmd_ev) begin
      if (io_s == nand_seq_pkg::CMD_RESET) begin
        next_st.mode        = M_IDLE;
        next_st.status_mode = 1'b0;
        next_st.op_abort    = 1'b1;
        next_st.fail        = 1'b0;
        next_st.busy        = 1'b1;
        next_st.op          = OP_NONE;
        next_st.tmr         = nand_seq_pkg::RST_CYC - 16'h0001;
      end else if (io_s == nand_seq_pkg::CMD_STATUS) begin
        next_st.status_mode = 1'b1;
      end else if (!st.busy) begin
        next_st.status_mode = 1'b0;
        next_st.addr_cnt    = 3'h0;
        next_st.mode        = M_IDLE;
        case (io_s)
          nand_seq_pkg::CMD_READ: begin
            if (st.status_mode && st.mode == M_READ) begin
              next_st.mode     = M_READ;
              next_st.addr_cnt = st.addr_cnt;
            end else begin
              next_st.mode = M_RSET;
            end
          end
          nand_seq_pkg::CMD_READ_GO: begin
            if (st.mode == M_RSET) begin
              next_st.busy    = 1'b1;
              next_st.op      = OP_READ;
              next_st.tmr     = nand_seq_pkg::READ_CYC - 16'h0001;
              next_st.read_go = 1'b1;
              next_st.mode    = M_RSET;
            end
          end
          nand_seq_pkg::CMD_LOAD: begin
            next_st.mode = M_LOAD;
          end
          nand_seq_pkg::CMD_COL_CHG: begin
            if (st.mode == M_LOAD) begin
              next_st.mode = M_LOAD;
            end
          end
          nand_seq_pkg::CMD_PROG, nand_seq_pkg::CMD_PROG_CACH: begin
            if (st.mode == M_LOAD && wp_s) begin
              next_st.busy    = 1'b1;
              next_st.op      = OP_PROG;
              next_st.tmr     = PROG_CYC - 16'h0001;
              next_st.prog_go = 1'b1;
            end
          end
          nand_seq_pkg::CMD_ERASE: begin
            next_st.mode = M_ESET;
          end
          nand_seq_pkg::CMD_ERASE_GO: begin
            if (st.mode == M_ESET && wp_s) begin
              next_st.busy     = 1'b1;
              next_st.op       = OP_ERASE;
              next_st.tmr      = ERASE_CYC - 16'h0001;
              next_st.erase_go = 1'b1;
            end
          end
          // any other command drops the load
          default: begin
            next_st.mode = M_IDLE;
          end
        endcase
      end
    end else if (addr_ev && !st.busy) begin
      if (st.addr_cnt != nand_seq_pkg::ADDR_LAST) begin
        next_st.addr_cnt = st.addr_cnt + 3'h1;
      end
      if (st.mode == M_ESET) begin
        if (st.addr_cnt == nand_seq_pkg::ADDR_COL_LO) begin
          next_st.row[7:0] = io_s;
        end else if (st.addr_cnt == nand_seq_pkg::ADDR_COL_HI) begin
          next_st.row[15:8] = io_s;
        end
      end else begin
        case (st.addr_cnt)
          nand_seq_pkg::ADDR_COL_LO: next_st.col[7:0]   = io_s;
          nand_seq_pkg::ADDR_COL_HI: next_st.col[11:8]  = io_s[3:0];
          nand_seq_pkg::ADDR_ROW_LO: next_st.row[7:0]   = io_s;
          nand_seq_pkg::ADDR_ROW_HI: next_st.row[15:8]  = io_s;
          default:                   next_st.row        = st.row;
        endcase
      end
    end else if (data_ev && st.mode == M_LOAD && !st.busy) begin
      next_st.wr_strobe = 1'b1;
      next_st.wr_data   = io_s;
      next_st.col       = st.col + 12'h001;
    end

    if (re_fall) begin
      if (st.status_mode) begin
        next_st.io_out = status;
      end else if (st.mode == M_READ && !st.busy) begin
        next_st.io_out = rd_data;
        next_st.col    = st.col + 12'h001;
      end
    end

    next_st.rb_oe_n = !next_st.busy;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st         <= '0;
      st.mode    <= M_IDLE;
      st.op      <= OP_NONE;
      st.busy    <= 1'b1;
      st.tmr     <= POR_CYC - 16'h0001;
      st.we_q    <= 1'b1;
      st.re_q    <= 1'b1;
      st.io_oe_n <= 1'b1;
      st.rb_oe_n <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign io_out          = st.io_out;
  assign io_oe_n         = st.io_oe_n;
  assign ready_busy_n    = 1'b0;
  assign ready_busy_oe_n = st.rb_oe_n;
  assign col_addr        = st.col;
  assign row_addr        = st.row;
  assign wr_strobe       = st.wr_strobe;
  assign wr_data         = st.wr_data;
  assign read_go         = st.read_go;
  assign prog_go         = st.prog_go;
  assign erase_go        = st.erase_go;
  assign op_abort        = st.op_abort;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  init_busy_a: assert property ($fell(srst) |-> !ready_busy_oe_n ##1
    !ready_busy_oe_n) else $error("busy not shown after reset");
  status_out_a: assert property (re_fall && st.status_mode |=>
    io_out == $past(status)) else $error("status byte not driven");
  status_hold_a: assert property (st.status_mode && !(cmd_ev &&
    io_s != nand_seq_pkg::CMD_STATUS &&
    (!st.busy || io_s == nand_seq_pkg::CMD_RESET))
    |=> st.status_mode) else $error("status mode left early");
  resume_a: assert property (cmd_ev && io_s == nand_seq_pkg::CMD_READ
    && st.status_mode && st.mode == M_READ && !st.busy |=>
    st.mode == M_READ && !st.status_mode && $stable(col_addr))
    else $error("read not resumed at column");
  wp_abort_a: assert property (!wp_s && st.busy &&
    (st.op == OP_PROG || st.op == OP_ERASE) |=> !st.busy ##1
    ready_busy_oe_n) else $error("write protect did not abort");
  fifth_a: assert property (addr_ev &&
    st.addr_cnt == nand_seq_pkg::ADDR_LAST |=> $stable(row_addr)
    && $stable(col_addr)) else $error("fifth address used");
  fail_bit_a: assert property (re_fall && st.status_mode
    |=> io_out[nand_seq_pkg::ST_FAIL_BIT] == $past(st.fail))
    else $error("fail bit wrong");
  reset_cmd_a: assert property (cmd_ev &&
    io_s == nand_seq_pkg::CMD_RESET |=> st.mode == M_IDLE &&
    !st.status_mode && op_abort) else $error("reset did not stop");
  erase_go_a: assert property (cmd_ev && !st.busy && wp_s &&
    io_s == nand_seq_pkg::CMD_ERASE_GO && st.mode == M_ESET
    |=> erase_go && st.op == OP_ERASE) else $error("erase not started");
  no_erase_a: assert property (erase_go |-> $past(st.mode) == M_ESET)
    else $error("erase without setup");
  abandon_a: assert property (cmd_ev && !st.busy &&
    st.mode == M_LOAD && io_s == nand_seq_pkg::CMD_READ
    |=> st.mode == M_RSET && !prog_go) else $error("load not dropped");

  prog_c: cover property (prog_go ##[1:20] !wp_s);
  erase_c: cover property (erase_go);
  resume_c: cover property (st.status_mode && st.mode == M_READ ##1
    !st.status_mode && st.mode == M_READ);
endmodule : nand_seq

/* File: dv/host_model.sv */
/*
  Host side model: drives the flash pins with slow strobes and stands in
  for the cell array. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  input  wire logic        rb_wire,
  input  wire logic [7:0]  io_out,
  input  wire logic [11:0] col_addr,
  output logic             ce_n,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             re_n,
  output logic             wp_n,
  output logic      [7:0]  io_in,
  output logic      [7:0]  rd_data,
  output logic             array_fail
);
  initial begin
    ce_n       = 1'b1;
    cle        = 1'b0;
    ale        = 1'b0;
    we_n       = 1'b1;
    re_n       = 1'b1;
    wp_n       = 1'b1;
    io_in      = 8'h00;
    array_fail = 1'b0;
  end

  // Array byte follows the column so a resumed read is recognisable
  assign rd_data = col_addr[7:0] ^ 8'h5A;

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // idle data lines rest at the inverse of the last byte put, 00h at start and after FFh
  task automatic put(input logic c, input logic a, input logic [7:0] d);
    @(posedge clk);
    ce_n  <= 1'b0;
    cle   <= c;
    ale   <= a;
    io_in <= d;
    hold(4);
    we_n <= 1'b0;
    hold(4);
    we_n <= 1'b1;
    hold(4);
    cle   <= 1'b0;
    ale   <= 1'b0;
    io_in <= ~d;
  endtask : put

  task automatic get(output logic [7:0] d);
    @(posedge clk);
    re_n <= 1'b0;
    hold(6);
    @(negedge clk);
    d = io_out;
    @(posedge clk);
    re_n <= 1'b1;
    hold(4);
  endtask : get

  task automatic wait_rdy(input int lim, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < lim && ok !== 1'b1; i++) begin
      @(negedge clk);
      ok = rb_wire;
    end
  endtask : wait_rdy

  task automatic set_wp(input logic v);
    @(posedge clk);
    wp_n <= v;
  endtask : set_wp

  task automatic set_fail(input logic v);
    @(posedge clk);
    array_fail <= v;
  endtask : set_fail
endmodule : host_model

/* File: dv/nand_host_command_rules_tb.sv */
/*
  Self-checking bench for the flash command sequencer.
  Assumes host_model drives the pins; shortened operation times.
*/
`timescale 1ns/1ps
module nand_host_command_rules_tb;
  localparam logic [15:0] PROG  = 16'h0064;
  localparam logic [15:0] ERASE = 16'h0096;
  localparam logic [15:0] POR   = 16'h00C8;

  logic        clk;
  logic        srst;
  logic        ce_n, cle, ale, we_n, re_n, wp_n, array_fail, rb_wire;
  logic        io_oe_n, ready_busy_n, ready_busy_oe_n, wr_strobe;
  logic        read_go, prog_go, erase_go, op_abort;
  logic [7:0]  io_in, io_out, rd_data, wr_data, last_wr;
  logic [11:0] col_addr;
  logic [15:0] row_addr;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n_rd = 0, n_pg = 0, n_er = 0, n_ab = 0, n_wr = 0;

  // Open-drain line with pull-up
  assign rb_wire = ready_busy_oe_n ? 1'b1 : ready_busy_n;

  nand_seq #(.PROG_CYC(PROG), .ERASE_CYC(ERASE), .POR_CYC(POR)) i_nand_seq (
    .clk(clk), .srst(srst), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .ready_busy_n(ready_busy_n),
    .ready_busy_oe_n(ready_busy_oe_n), .rd_data(rd_data),
    .array_fail(array_fail), .col_addr(col_addr), .row_addr(row_addr),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .read_go(read_go),
    .prog_go(prog_go), .erase_go(erase_go), .op_abort(op_abort)
  );

  host_model i_host_model (
    .clk(clk), .rb_wire(rb_wire), .io_out(io_out), .col_addr(col_addr),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .io_in(io_in), .rd_data(rd_data),
    .array_fail(array_fail)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulse counters and run limit
  always @(posedge clk) begin
    cyc++;
    if (read_go === 1'b1) n_rd++;
    if (prog_go === 1'b1) n_pg++;
    if (erase_go === 1'b1) n_er++;
    if (op_abort === 1'b1) n_ab++;
    if (wr_strobe === 1'b1) begin
      n_wr++;
      last_wr = wr_data;
    end
    if (cyc == 10000) begin
      err_total++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic results();
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  task automatic cmd(input logic [7:0] c);
    i_host_model.put(1'b1, 1'b0, c);
  endtask : cmd

  task automatic adr(input logic [7:0] a);
    i_host_model.put(1'b0, 1'b1, a);
  endtask : adr

  task automatic addr4(input logic [7:0] a, b, c, d);
    adr(a);
    adr(b);
    adr(c);
    adr(d);
  endtask : addr4

  task automatic waitr(input int lim);
    logic ok;
    i_host_model.wait_rdy(lim, ok);
    chk("ready", ok, 1'b1);
  endtask : waitr

  task automatic st(input logic [7:0] exp);
    logic [7:0] d;
    cmd(nand_seq_pkg::CMD_STATUS);
    i_host_model.get(d);
    chk("status", d, exp);
  endtask : st

  task automatic t_init();
    logic [7:0] d;
    chk("rb_init", rb_wire, 1'b0);
    cmd(nand_seq_pkg::CMD_STATUS);
    i_host_model.get(d);
    chk("st_init", d, 8'h80);
    chk("rb_init2", rb_wire, 1'b0);
    waitr(POR);
    st(8'hE0);
  endtask : t_init

  task automatic t_prog();
    int p0 = n_pg;
    int w0 = n_wr;
    cmd(nand_seq_pkg::CMD_LOAD);
    addr4(8'h34, 8'h01, 8'h00, 8'h00);
    i_host_model.put(1'b0, 1'b0, 8'hC3);
    wt(5);
    chk("wr_cnt", n_wr - w0, 1);
    chk("wr_data", last_wr, 8'hC3);
    chk("col_inc", col_addr, 12'h135);
    i_host_model.set_fail(1'b1);
    cmd(nand_seq_pkg::CMD_PROG);
    wt(5);
    chk("prog_go", n_pg - p0, 1);
    chk("rb_prog", rb_wire, 1'b0);
    waitr(PROG + 20);
    st(8'hE1);
    i_host_model.set_fail(1'b0);
  endtask : t_prog

  task automatic t_reset();
    int e0 = n_er;
    int a0 = n_ab;
    // block 0 failed program, retired; go to block 1
    // each page programmed once, no bad block erased
    cmd(nand_seq_pkg::CMD_LOAD);
    addr4(8'h00, 8'h00, 8'h40, 8'h00);
    i_host_model.put(1'b0, 1'b0, 8'h0F);
    cmd(nand_seq_pkg::CMD_PROG);
    cmd(nand_seq_pkg::CMD_ERASE);
    cmd(nand_seq_pkg::CMD_ERASE_GO);
    chk("busy_refuse", n_er - e0, 0);
    cmd(nand_seq_pkg::CMD_RESET);
    wt(5);
    chk("rst_abort", n_ab - a0, 1);
    waitr(150);
    st(8'hE0);
  endtask : t_reset

  task automatic t_read();
    logic [7:0] d;
    int r0 = n_rd;
    cmd(nand_seq_pkg::CMD_READ);
    addr4(8'h2D, 8'h00, 8'h45, 8'h00);
    adr(8'hEE);
    cmd(nand_seq_pkg::CMD_READ_GO);
    wt(5);
    chk("read_go", n_rd - r0, 1);
    chk("col5", col_addr, 12'h02D);
    chk("row5", row_addr, 16'h0045);
    waitr(600);
    st(8'hE0);
    i_host_model.get(d);
    chk("st_stay", d, 8'hE0);
    cmd(nand_seq_pkg::CMD_READ);
    i_host_model.get(d);
    // byte is not 00h, so the block stays good
    chk("resume", d, 8'h77);
  endtask : t_read

  task automatic t_erase();
    int p0 = n_pg;
    int e0 = n_er;
    int a0 = n_ab;
    cmd(nand_seq_pkg::CMD_ERASE);
    addr4(8'h80, 8'h00, 8'h00, 8'h00);
    cmd(nand_seq_pkg::CMD_READ);
    wt(5);
    chk("no_confirm", n_er - e0, 0);
    cmd(nand_seq_pkg::CMD_LOAD);
    cmd(nand_seq_pkg::CMD_READ);
    wt(5);
    chk("load_read", n_pg - p0, 0);
    cmd(nand_seq_pkg::CMD_LOAD);
    addr4(8'h00, 8'h00, 8'h80, 8'h00);
    cmd(nand_seq_pkg::CMD_ERASE);
    adr(8'h80);
    adr(8'h00);
    cmd(nand_seq_pkg::CMD_ERASE_GO);
    wt(5);
    chk("load_drop", n_pg - p0, 0);
    chk("erase_go", n_er - e0, 1);
    chk("erase_row", row_addr, 16'h0080);
    i_host_model.set_wp(1'b0);
    wt(8);
    chk("wp_abort", n_ab - a0, 1);
    waitr(ERASE + 20);
    st(8'h61);
    i_host_model.set_wp(1'b1);
  endtask : t_erase

  initial begin
    srst = 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wt(1);
    t_init();
    t_prog();
    t_reset();
    t_read();
    t_erase();
    results();
  end
endmodule : nand_host_command_rules_tb
